/* brc_cfg_top.sv */
// Top of the half-bridge PWM configuration block: registers, routing and protection controls
// Summary of operation
// [RL1] Per channel freewheel bit: 0 passive, 1 active; resets to 0.
// [RL2] Per channel 3-bit route picks generator one to eight; resets to one.
// [RL3] First route register: channel one bits 2:0, channel two bits 5:3.
// [RL4] Software writes zero into the two top bits of route registers.
// [RL5] Two-bit generator rate: 80Hz, 100Hz, 200Hz, 2kHz; resets to 80Hz.
// [RL6] Rate fields packed two bits per generator across two registers.
// [RL7] Eight-bit duty per generator; high fraction is value over 255.
// [RL8] Per channel edge-rate bit: 0 slow, 1 fast; resets to slow.
// [RL9] Per channel open-load disable bit: 0 detection on, 1 off.
// [RL10] Open-load mask bit 7: 0 reports on fault pin, 1 hides.
// [RL11] Bit 6: 0 turns channel off on open load, 1 keeps running.
// [RL12] Bit 4 picks overcurrent turn-off slope: 0 fast, 1 slow.
// [RL13] Three-bit deglitch select in bits 7:5 sets overcurrent filter time.
// [RL14] Software writes zero into reserved bits of the fault control register.
// [RL15] Channel mode bit: 0 register on/off, 1 chopped by routed generator.
// [RL16] Generator stop bit: 0 runs, 1 stops that generator.
// [RL17] Period from divided clock; duty of 255 ticks; updates at boundary.
// [RL18] Routes to generators seven or eight hold the chopped output off.
// [RL19] Reset returns all registers to defaults and stops every generator; the code clears the stop bits, so every generator runs.
`timescale 1ns/100ps
`default_nettype none
module brc_cfg_top
  import brc_pkg::*;
#(
  parameter int unsigned TICK_DIV [4] = TICK_DIV_DFLT,
  parameter int unsigned OCF_CYC  [8] = OCF_CYC_DFLT
)(
  input  wire logic                       clk_i,
  input  wire logic                       arst_n_i,
  input  wire logic                       reg_wr_i,
  input  wire logic                       reg_rd_i,
  input  wire logic [7:0]                 reg_addr_i,
  input  wire logic [7:0]                 reg_wdata_i,
  input  wire logic [CH_NUM-1:0]          open_load_i,
  input  wire logic                       overcurrent_i,
  output logic [7:0]                      reg_rdata_o,
  output logic                            reg_rvalid_o,
  output brc_chan_cfg_t [CH_NUM-1:0]      chan_cfg_o,
  output brc_prot_cfg_t                   prot_cfg_o,
  output logic [CH_NUM-1:0]               chan_gate_o,
  output logic [CH_NUM-1:0]               chan_ol_shutdown_o,
  output logic                            open_load_fault_o,
  output logic                            overcurrent_trip_o
);

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [7:0]         regs_r    [REG_NUM];
  logic [7:0]         regs_nxt  [REG_NUM];
  logic [REG_NUM-1:0] wr_hit;
  logic [REG_NUM-1:0] rd_hit;
  logic [7:0]         rdata_r,  rdata_nxt;
  logic               rvalid_r, rvalid_nxt;

  always_comb
  begin
    wr_hit = reg_hit(reg_addr_i);
    rd_hit = reg_hit(reg_addr_i);
    // Reserved read-only bits masked to zero; unmapped writes dropped
    for (int i = 0; i < REG_NUM; i++)
    begin
      regs_nxt[i] = (reg_wr_i && wr_hit[i]) ? (reg_wdata_i & REG_MASK[i]) : regs_r[i];
    end
    rdata_nxt = '0;
    for (int i = 0; i < REG_NUM; i++)
    begin
      if (rd_hit[i])
      begin
        rdata_nxt = regs_r[i];
      end
    end
    rvalid_nxt = reg_rd_i;
    if (!reg_rd_i)
    begin
      rdata_nxt = rdata_r;
    end
  end

  genvar gr;
  generate
    for (gr = 0; gr < REG_NUM; gr++)
    begin : g_reg
      always_ff @(posedge clk_i or negedge arst_n_i)
      begin
        if (!arst_n_i)
        begin
          regs_r[gr] <= REG_RST; // [RL19]
        end
        else
        begin
          regs_r[gr] <= regs_nxt[gr];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rdata_r  <= '0;
      rvalid_r <= 1'b0;
    end
    else
    begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // ****************************************************************
  // Field extraction
  // ****************************************************************
  brc_chan_cfg_t [CH_NUM-1:0] cfg_d;
  brc_prot_cfg_t              prot_d;
  logic [GEN_NUM-1:0]         gen_stop;
  logic [RATE_W-1:0]          gen_rate [GEN_NUM];
  logic [7:0]                 gen_duty [GEN_NUM];

  always_comb
  begin
    for (int c = 0; c < CH_NUM; c++)
    begin
      cfg_d[c].channel_freewheel_sel   = regs_r[RI_FW][c];    // [RL1]
      cfg_d[c].channel_edge_rate_sel   = regs_r[RI_EDGE][c];  // [RL8]
      cfg_d[c].channel_open_load_off   = regs_r[RI_OLOFF][c]; // [RL9]
      cfg_d[c].channel_chop_mode       = regs_r[RI_MODE][c];  // [RL15]
      cfg_d[c].channel_generator_route =                      // [RL2] [RL3]
        regs_r[RI_ROUTE + c / ROUTE_PER_REG][(c % ROUTE_PER_REG) * ROUTE_W +: ROUTE_W];
    end
    for (int g = 0; g < GEN_NUM; g++)
    begin
      gen_stop[g] = regs_r[RI_STOP][g]; // [RL16]
      gen_rate[g] = regs_r[RI_RATE + g / RATE_PER_REG][(g % RATE_PER_REG) * RATE_W +: RATE_W]; // [RL5] [RL6]
      gen_duty[g] = regs_r[RI_DUTY + g]; // [RL7]
    end
    // Reserved bits kept as written; software keeps them zero [RL4] [RL14]
    prot_d.open_load_fault_mask      = regs_r[RI_FAULT][OLM_BIT]; // [RL10]
    prot_d.open_load_keep_running    = regs_r[RI_FAULT][OLK_BIT]; // [RL11]
    prot_d.overcurrent_shutoff_slope = regs_r[RI_FAULT][OCS_BIT]; // [RL12]
    prot_d.overcurrent_deglitch_sel  = regs_r[RI_OCF][OCF_LSB +: OCF_W]; // [RL13]
  end

  // ****************************************************************
  // Generators
  // ****************************************************************
  logic [ROUTE_CODES-1:0] gen_pwm;

  genvar gg;
  generate
    for (gg = 0; gg < GEN_NUM; gg++)
    begin : g_gen
      brc_pwm_gen #(
        .TICK_DIV (TICK_DIV)
      ) u_gen (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .stop_i   (gen_stop[gg]),
        .rate_i   (gen_rate[gg]),
        .duty_i   (gen_duty[gg]),
        .pwm_o    (gen_pwm[gg])
      );
    end
  endgenerate

  // Codes with no generator behind them read as a dead source [RL18]
  assign gen_pwm[ROUTE_CODES-1:GEN_NUM] = '0;

  // ****************************************************************
  // Open-load input synchronisers
  // ****************************************************************
  logic [2:0]        ol_sync_r [CH_NUM];
  logic [CH_NUM-1:0] ol_stab_r, ol_stab_nxt;

  generate
    for (gg = 0; gg < CH_NUM; gg++)
    begin : g_olsync
      always_ff @(posedge clk_i or negedge arst_n_i)
      begin
        if (!arst_n_i)
        begin
          ol_sync_r[gg] <= '0;
        end
        else
        begin
          ol_sync_r[gg] <= {ol_sync_r[gg][1:0], open_load_i[gg]};
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Channel outputs
  // ****************************************************************
  brc_chan_cfg_t [CH_NUM-1:0] cfg_r;
  brc_prot_cfg_t              prot_r;
  logic [CH_NUM-1:0]          gate_r,  gate_nxt;
  logic [CH_NUM-1:0]          shut_r,  shut_nxt;
  logic [CH_NUM-1:0]          ol_evt;
  logic                       fault_r, fault_nxt;

  always_comb
  begin
    for (int c = 0; c < CH_NUM; c++)
    begin
      ol_stab_nxt[c] = (ol_sync_r[c][1] == ol_sync_r[c][2]) ? ol_sync_r[c][2] : ol_stab_r[c];
      // Disabled detection drops the event at source [RL9]
      ol_evt[c] = ol_stab_r[c] && !cfg_d[c].channel_open_load_off;
      // Register mode holds the gate high; chop mode follows routed generator [RL15] [RL18]
      gate_nxt[c] = cfg_d[c].channel_chop_mode ? gen_pwm[cfg_d[c].channel_generator_route] : 1'b1;
      shut_nxt[c] = ol_evt[c] && !prot_d.open_load_keep_running; // [RL11]
    end
    fault_nxt = (|ol_evt) && !prot_d.open_load_fault_mask; // [RL10]
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ol_stab_r <= '0;
      cfg_r     <= '0;
      prot_r    <= '0;
      gate_r    <= '0;
      shut_r    <= '0;
      fault_r   <= 1'b0;
    end
    else
    begin
      ol_stab_r <= ol_stab_nxt;
      cfg_r     <= cfg_d;
      prot_r    <= prot_d;
      gate_r    <= gate_nxt;
      shut_r    <= shut_nxt;
      fault_r   <= fault_nxt;
    end
  end

  // ****************************************************************
  // Overcurrent filter
  // ****************************************************************
  logic oc_trip;

  brc_overcurrent_deglitch_sel #(
    .FILT_CYC (OCF_CYC)
  ) u_ocf (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .raw_i    (overcurrent_i),
    .sel_i    (prot_d.overcurrent_deglitch_sel),
    .trip_o   (oc_trip)
  );

  assign reg_rdata_o        = rdata_r;
  assign reg_rvalid_o       = rvalid_r;
  assign chan_cfg_o         = cfg_r;
  assign prot_cfg_o         = prot_r;
  assign chan_gate_o        = gate_r;
  assign chan_ol_shutdown_o = shut_r;
  assign open_load_fault_o  = fault_r;
  assign overcurrent_trip_o = oc_trip;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  property p_fw_wr;
    (reg_wr_i && reg_addr_i == REG_ADDR[RI_FW]) |-> ##2
      chan_cfg_o[0].channel_freewheel_sel == $past(reg_wdata_i[0], 2);
  endproperty
  a_fw_wr: assert property (p_fw_wr) else $error("freewheel bit not applied"); // [RL1]

  property p_route_a;
    (reg_wr_i && reg_addr_i == REG_ADDR[RI_ROUTE]) |-> ##2
      chan_cfg_o[1].channel_generator_route == $past(reg_wdata_i[5:3], 2);
  endproperty
  a_route_a: assert property (p_route_a) else $error("channel two route misplaced"); // [RL3]

  property p_rate_b;
    (reg_wr_i && reg_addr_i == REG_ADDR[RI_RATE + 1]) |=> gen_rate[5] == $past(reg_wdata_i[3:2]);
  endproperty
  a_rate_b: assert property (p_rate_b) else $error("generator six rate misplaced"); // [RL6]

  property p_edge;
    (reg_wr_i && reg_addr_i == REG_ADDR[RI_EDGE]) |-> ##2
      chan_cfg_o[5].channel_edge_rate_sel == $past(reg_wdata_i[5], 2);
  endproperty
  a_edge: assert property (p_edge) else $error("edge rate bit not applied"); // [RL8]

  property p_regmode;
    !cfg_d[0].channel_chop_mode |=> chan_gate_o[0];
  endproperty
  a_regmode: assert property (p_regmode) else $error("register mode gate low"); // [RL15]

  property p_dead_route;
    (cfg_d[2].channel_chop_mode && cfg_d[2].channel_generator_route[2:1] == 2'b11) |=> !chan_gate_o[2];
  endproperty
  a_dead_route: assert property (p_dead_route) else $error("unimplemented route drove gate"); // [RL18]

  property p_ol_mask;
    prot_d.open_load_fault_mask |=> !open_load_fault_o;
  endproperty
  a_ol_mask: assert property (p_ol_mask) else $error("masked open load reported"); // [RL10]

  property p_ol_keep;
    prot_d.open_load_keep_running |=> chan_ol_shutdown_o == '0;
  endproperty
  a_ol_keep: assert property (p_ol_keep) else $error("shutdown while keep running"); // [RL11]

  property p_ol_dis;
    (cfg_d[3].channel_open_load_off) |=> !chan_ol_shutdown_o[3];
  endproperty
  a_ol_dis: assert property (p_ol_dis) else $error("disabled channel shut down"); // [RL9]

  property p_slope;
    (reg_wr_i && reg_addr_i == REG_ADDR[RI_FAULT]) |-> ##2
      prot_cfg_o.overcurrent_shutoff_slope == $past(reg_wdata_i[4], 2);
  endproperty
  a_slope: assert property (p_slope) else $error("slope bit not applied"); // [RL12]

  property p_unmapped;
    (reg_rd_i && reg_hit(reg_addr_i) == '0) |=> reg_rvalid_o && reg_rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero"); // [RL19]

  c_chop: cover property (cfg_d[0].channel_chop_mode && $rose(chan_gate_o[0]));
  c_fault: cover property ($rose(open_load_fault_o));
  c_trip: cover property ($rose(overcurrent_trip_o));
  c_read: cover property (reg_rvalid_o && reg_rdata_o != 8'h00);

endmodule
`default_nettype wire

/* brc_overcurrent_deglitch_sel.sv */
// Overcurrent deglitch filter with selectable filter time
`timescale 1ns/100ps
`default_nettype none
module brc_overcurrent_deglitch_sel
  import brc_pkg::*;
#(
  parameter int unsigned FILT_CYC [8] = OCF_CYC_DFLT
)(
  input  wire logic             clk_i,
  input  wire logic             arst_n_i,
  input  wire logic             raw_i,
  input  wire logic [OCF_W-1:0] sel_i,
  output logic                  trip_o
);

  logic [2:0]       sync_r;
  logic             stab_r, stab_nxt;
  logic [CNT_W-1:0] cnt_r,  cnt_nxt;
  logic             trip_r, trip_nxt;

  // ****************************************************************
  // Filter
  // ****************************************************************
  always_comb
  begin
    // Only the second and third stages are compared
    stab_nxt = (sync_r[1] == sync_r[2]) ? sync_r[2] : stab_r;
    cnt_nxt  = '0;
    trip_nxt = 1'b0;
    if (stab_r)
    begin
      if (cnt_r >= CNT_W'(FILT_CYC[sel_i] - 1))
      begin
        cnt_nxt  = cnt_r;
        trip_nxt = 1'b1;
      end
      else
      begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sync_r <= '0;
      stab_r <= 1'b0;
      cnt_r  <= '0;
      trip_r <= 1'b0;
    end
    else
    begin
      sync_r <= {sync_r[1:0], raw_i};
      stab_r <= stab_nxt;
      cnt_r  <= cnt_nxt;
      trip_r <= trip_nxt;
    end
  end

  assign trip_o = trip_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  property p_flt_glitch;
    !stab_r |=> !trip_r;
  endproperty
  a_flt_glitch: assert property (p_flt_glitch) else $error("trip without stable input"); // [RL13]

  property p_flt_min;
    // Shortest filter time in use is two cycles
    $rose(stab_r) |-> !trip_r [*2];
  endproperty
  a_flt_min: assert property (p_flt_min) else $error("trip before filter time"); // [RL13]

endmodule
`default_nettype wire

/* brc_pkg.sv */
// Shared constants, register map and types for the half-bridge PWM configuration block
package brc_pkg;

  // ****************************************************************
  // Sizes and clock
  // ****************************************************************
  localparam int CH_NUM        = 6;
  localparam int GEN_NUM       = 6;
  localparam int ROUTE_CODES   = 8;
  localparam int REG_NUM       = 18;
  localparam int CNT_W         = 16;
  localparam int CLK_HZ        = 100_000_000;
  localparam int CLK_PERIOD_NS = 10;

  // ****************************************************************
  // Generator timing
  // ****************************************************************
  localparam int         DUTY_STEPS = 255;
  localparam logic [7:0] STEP_LAST  = 8'hfe;
  localparam logic [7:0] DUTY_FULL  = 8'hff;
  localparam logic [7:0] DUTY_ZERO  = 8'h00;
  localparam int RATE_HZ [4] = '{80, 100, 200, 2000};
  localparam int unsigned TICK_DIV_DFLT [4] = '{
    CLK_HZ / (RATE_HZ[0] * DUTY_STEPS), CLK_HZ / (RATE_HZ[1] * DUTY_STEPS),
    CLK_HZ / (RATE_HZ[2] * DUTY_STEPS), CLK_HZ / (RATE_HZ[3] * DUTY_STEPS)};

  // ****************************************************************
  // Overcurrent deglitch times, in ns, by select code
  // ****************************************************************
  localparam int OCF_NS [8] = '{10000, 5000, 2500, 1000, 60000, 40000, 30000, 20000};
  localparam int unsigned OCF_CYC_DFLT [8] = '{
    OCF_NS[0] / CLK_PERIOD_NS, OCF_NS[1] / CLK_PERIOD_NS, OCF_NS[2] / CLK_PERIOD_NS,
    OCF_NS[3] / CLK_PERIOD_NS, OCF_NS[4] / CLK_PERIOD_NS, OCF_NS[5] / CLK_PERIOD_NS,
    OCF_NS[6] / CLK_PERIOD_NS, OCF_NS[7] / CLK_PERIOD_NS};

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int RI_MODE  = 0;
  localparam int RI_STOP  = 1;
  localparam int RI_FW    = 2;
  localparam int RI_ROUTE = 3;
  localparam int RI_RATE  = 6;
  localparam int RI_DUTY  = 8;
  localparam int RI_EDGE  = 14;
  localparam int RI_OLOFF = 15;
  localparam int RI_FAULT = 16;
  localparam int RI_OCF   = 17;
  localparam logic [7:0] REG_ADDR [REG_NUM] = '{
    8'h0b, 8'h0c, 8'h0d, 8'h0f, 8'h10, 8'h11, 8'h13, 8'h14, 8'h15,
    8'h16, 8'h17, 8'h18, 8'h19, 8'h1a, 8'h1d, 8'h1f, 8'h20, 8'h21};
  localparam logic [7:0] REG_MASK [REG_NUM] = '{
    8'h3f, 8'h3f, 8'h3f, 8'hff, 8'hff, 8'hff, 8'hff, 8'h0f, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h3f, 8'h3f, 8'hff, 8'hff};
  localparam logic [7:0] REG_RST = 8'h00;

  // ****************************************************************
  // Field layout
  // ****************************************************************
  localparam int ROUTE_W       = 3;
  localparam int ROUTE_PER_REG = 2;
  localparam int RATE_W        = 2;
  localparam int RATE_PER_REG  = 4;
  localparam int OLM_BIT       = 7;
  localparam int OLK_BIT       = 6;
  localparam int OCS_BIT       = 4;
  localparam int OCF_LSB       = 5;
  localparam int OCF_W         = 3;

  typedef struct packed {
    logic               channel_freewheel_sel;
    logic               channel_edge_rate_sel;
    logic               channel_open_load_off;
    logic               channel_chop_mode;
    logic [ROUTE_W-1:0] channel_generator_route;
  } brc_chan_cfg_t;

  typedef struct packed {
    logic             open_load_fault_mask;
    logic             open_load_keep_running;
    logic             overcurrent_shutoff_slope;
    logic [OCF_W-1:0] overcurrent_deglitch_sel;
  } brc_prot_cfg_t;

  // One-hot register hit for an address
  function automatic logic [REG_NUM-1:0] reg_hit(input logic [7:0] addr);
    logic [REG_NUM-1:0] hit;
    hit = '0;
    for (int i = 0; i < REG_NUM; i++)
    begin
      if (addr == REG_ADDR[i])
      begin
        hit[i] = 1'b1;
      end
    end
    return hit;
  endfunction

endpackage

/* brc_pwm_gen.sv */
// One internal PWM generator with period-boundary update of duty and rate
`timescale 1ns/100ps
`default_nettype none
module brc_pwm_gen
  import brc_pkg::*;
#(
  parameter int unsigned TICK_DIV [4] = TICK_DIV_DFLT
)(
  input  wire logic              clk_i,
  input  wire logic              arst_n_i,
  input  wire logic              stop_i,
  input  wire logic [RATE_W-1:0] rate_i,
  input  wire logic [7:0]        duty_i,
  output logic                   pwm_o
);

  logic [CNT_W-1:0]  pre_r,  pre_nxt;
  logic [7:0]        step_r, step_nxt;
  logic [7:0]        duty_r, duty_nxt;
  logic [RATE_W-1:0] rate_r, rate_nxt;
  logic              pwm_r,  pwm_nxt;
  logic              tick;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    tick     = (pre_r >= CNT_W'(TICK_DIV[rate_r] - 1));
    pre_nxt  = tick ? '0 : pre_r + 1'b1;
    step_nxt = step_r;
    duty_nxt = duty_r;
    rate_nxt = rate_r;
    if (stop_i)
    begin
      // Stopped: hold at period start, track inputs for a clean restart [RL16]
      pre_nxt  = '0;
      step_nxt = '0;
      duty_nxt = duty_i;
      rate_nxt = rate_i;
    end
    else if (tick)
    begin
      if (step_r == STEP_LAST)
      begin
        // New settings only at the boundary, so no runt pulses [RL17]
        step_nxt = '0;
        duty_nxt = duty_i;
        rate_nxt = rate_i;
      end
      else
      begin
        step_nxt = step_r + 1'b1;
      end
    end
    // High for duty of 255 steps; 255 never drops [RL7] [RL17]
    pwm_nxt = !stop_i && (step_nxt < duty_nxt);
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pre_r  <= '0;
      step_r <= '0;
      duty_r <= DUTY_ZERO;
      rate_r <= '0;
      pwm_r  <= 1'b0;
    end
    else
    begin
      pre_r  <= pre_nxt;
      step_r <= step_nxt;
      duty_r <= duty_nxt;
      rate_r <= rate_nxt;
      pwm_r  <= pwm_nxt;
    end
  end

  assign pwm_o = pwm_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  property p_gen_stop_low;
    stop_i |=> !pwm_r;
  endproperty
  a_gen_stop_low: assert property (p_gen_stop_low) else $error("stopped generator drives high"); // [RL16]

  property p_gen_full_on;
    (!stop_i && duty_r == DUTY_FULL && duty_i == DUTY_FULL) [*2] |=> pwm_r;
  endproperty
  a_gen_full_on: assert property (p_gen_full_on) else $error("full duty dropped low"); // [RL7]

  property p_gen_hold;
    (!stop_i && step_r != STEP_LAST) |=> $stable(duty_r) && $stable(rate_r);
  endproperty
  a_gen_hold: assert property (p_gen_hold) else $error("settings changed mid period"); // [RL17]

endmodule
`default_nettype wire

/* brc_stage_model.sv */
// Behavioural power-stage model reporting open-load and overcurrent levels
`timescale 1ns/100ps
`default_nettype none
module brc_stage_model
  import brc_pkg::*;
(
  input  wire logic [CH_NUM-1:0] ol_req_i,
  input  wire logic              oc_req_i,
  output logic [CH_NUM-1:0]      open_load_o,
  output logic                   overcurrent_o
);
  // Comparator levels follow the bench command; the block does its own sync
  assign open_load_o   = ol_req_i;
  assign overcurrent_o = oc_req_i;
endmodule
`default_nettype wire

/* tb.sv */
// Self-checking bench for the half-bridge PWM configuration block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb;
  import brc_pkg::*;
  logic                       clk_i    = 1'b0;
  logic                       arst_n_i = 1'b0;
  logic                       wr       = 1'b0;
  logic                       rd       = 1'b0;
  logic                       oc_req   = 1'b0;
  logic [7:0]                 addr     = 8'h00;
  logic [7:0]                 wd       = 8'h00;
  logic [CH_NUM-1:0]          ol_req   = '0;
  logic [7:0]                 rdata;
  logic [CH_NUM-1:0]          ol;
  logic [CH_NUM-1:0]          gate;
  logic [CH_NUM-1:0]          olsd;
  logic                       rvalid;
  logic                       oc;
  logic                       olf;
  logic                       trip;
  brc_chan_cfg_t [CH_NUM-1:0] ccfg;
  brc_prot_cfg_t              pcfg;
  int                         n_errors  = 0;
  int                         cmp_count = 0;
  int                         cyc       = 0;
  int                         hi;

  // ****************************************************************
  // Clock, design and stage model
  // ****************************************************************
  always #5 clk_i = ~clk_i;

  // Short divider and filter counts keep whole periods within the run
  brc_cfg_top #(.TICK_DIV('{4, 5, 6, 2}), .OCF_CYC('{10, 5, 3, 2, 20, 16, 12, 8})) u_dut (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
    .reg_wdata_i(wd), .open_load_i(ol), .overcurrent_i(oc), .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .chan_cfg_o(ccfg), .prot_cfg_o(pcfg), .chan_gate_o(gate),
    .chan_ol_shutdown_o(olsd), .open_load_fault_o(olf), .overcurrent_trip_o(trip));

  brc_stage_model u_stage (.ol_req_i(ol_req), .oc_req_i(oc_req), .open_load_o(ol), .overcurrent_o(oc));

  // ****************************************************************
  // Bus tasks and scenarios
  // ****************************************************************
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr   <= 1'b1;
    addr <= a;
    wd   <= d;
    @(posedge clk_i);
    wr <= 1'b0;
    @(posedge clk_i);
    #1;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk_i);
    rd <= 1'b0;
    // Valid stands one cycle only
    #1;
    `CHK("rvalid", 1'b1, rvalid)
    `CHK("rdata", e, rdata)
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic t_reset();
    foreach (REG_ADDR[i]) rd_chk(REG_ADDR[i], 8'h00);
    rd_chk(8'h12, 8'h00);
    `CHK("gate", 6'h3f, gate)
    `CHK("ccfg", 42'h0, ccfg)
    `CHK("pcfg", 6'h00, pcfg)
    $display("t_reset done");
  endtask

  task automatic t_cfg();
    wr_reg(8'h0d, 8'h2a);
    wr_reg(8'h1d, 8'h15);
    wr_reg(8'h1f, 8'h3f);
    wr_reg(8'h0f, 8'h2b);
    wr_reg(8'h14, 8'hff);
    rd_chk(8'h0f, 8'h2b);
    rd_chk(8'h14, 8'h0f);
    `CHK("ch1", 7'h33, ccfg[0])
    `CHK("ch2", 7'h55, ccfg[1])
    `CHK("ch6", 7'h50, ccfg[5])
    wr_reg(8'h1f, 8'h00);
    wr_reg(8'h14, 8'h00);
    $display("t_cfg done");
  endtask

  task automatic t_prot();
    wr_reg(8'h20, 8'h90);
    wr_reg(8'h21, 8'ha0);
    rd_chk(8'h21, 8'ha0);
    `CHK("pcfg", 6'h2d, pcfg)
    @(posedge clk_i);
    ol_req <= 6'h01;
    wait_cyc(8);
    `CHK("olsd", 6'h01, olsd)
    `CHK("olf", 1'b0, olf)
    wr_reg(8'h20, 8'h40);
    wait_cyc(4);
    `CHK("olsd", 6'h00, olsd)
    `CHK("olf", 1'b1, olf)
    wr_reg(8'h1f, 8'h01);
    wait_cyc(4);
    `CHK("oloff", 1'b0, olf)
    @(posedge clk_i);
    ol_req <= 6'h00;
    oc_req <= 1'b1;
    wait_cyc(10);
    `CHK("trip", 1'b0, trip)
    wait_cyc(20);
    `CHK("trip", 1'b1, trip)
    @(posedge clk_i);
    oc_req <= 1'b0;
    $display("t_prot done");
  endtask

  task automatic high_count(input int n);
    hi = 0;
    repeat (n)
    begin
      @(posedge clk_i);
      #1;
      hi += int'(gate[0]);
    end
  endtask

  task automatic t_pwm();
    wr_reg(8'h0b, 8'h01);
    wr_reg(8'h0f, 8'h00);
    wr_reg(8'h15, 8'hff);
    wait_cyc(1100);
    `CHK("full", 1'b1, gate[0])
    wr_reg(8'h15, 8'h80);
    wait_cyc(1100);
    high_count(1020);
    `CHK("hi80", 512, hi)
    wr_reg(8'h13, 8'h03);
    wait_cyc(1100);
    high_count(510);
    `CHK("hi2k", 256, hi)
    wr_reg(8'h0f, 8'h06);
    wait_cyc(4);
    `CHK("route7", 1'b0, gate[0])
    wr_reg(8'h0f, 8'h00);
    wr_reg(8'h0c, 8'h01);
    wait_cyc(4);
    `CHK("stop", 1'b0, gate[0])
    $display("t_pwm done");
  endtask

  task automatic end_sim();
    $display("Compares %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ****************************************************************
  // Main sequence and hang guard
  // ****************************************************************
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      end_sim();
    end
  end

  initial
  begin
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    t_reset();
    t_cfg();
    t_prot();
    t_pwm();
    // Mid-run reset brings every register back
    @(posedge clk_i);
    arst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    t_reset();
    end_sim();
  end
endmodule
`default_nettype wire
